// File: core/jtp_pkg.sv
// package for the test access port block: instruction codes, field layouts, timing
// assumes a single 125 MHz system clock; jtag pins arrive asynchronously
package jtp_pkg;
   // instruction register and data register widths
   localparam int IR_W = 4;
   localparam int DR_W = 32;
   // instruction codes (arbitrary; bypass is all ones as usual)
   localparam logic [3:0] INS_EXTEST   = 4'h0;
   localparam logic [3:0] INS_SAMPLE   = 4'h1;
   localparam logic [3:0] INS_DEVICE_IDENTIFICATION_WORD   = 4'h2;
   localparam logic [3:0] INS_USERCODE = 4'h3;
   localparam logic [3:0] INS_CHIPTAP  = 4'h4;
   localparam logic [3:0] INS_BYPASS   = 4'hf;
   localparam logic [3:0] IR_CAPTURE   = 4'h1;
   // identification word fields; values are arbitrary
   localparam logic [3:0]  ID_VERSION  = 4'h0;
   localparam logic [15:0] ID_PART     = 16'h0001;
   localparam logic [10:0] ID_MAKER    = 11'h001;
   // user code layout: user tag at [31:22], revision at [7:0]
   localparam int UC_TAG_LSB = 22;
   localparam int UC_TAG_W   = 10;
   localparam int UC_REV_W   = 8;
   localparam logic [7:0] SILICON_REV = 8'h01; // arbitrary value
   // security register bit positions
   localparam int SEC_JTAG_OFF = 0;
   localparam int SEC_TAG_LSB  = 22;
   // system clock timing
   localparam int CLK_MHZ = 125;
   localparam int CLK_PS  = 8000;

   // tap controller states
   typedef enum logic [3:0] {
      S_RESET = 4'h0, S_IDLE = 4'h1, S_SEL_DR = 4'h2, S_CAP_DR = 4'h3,
      S_SH_DR = 4'h4, S_EX1_DR = 4'h5, S_PA_DR = 4'h6, S_EX2_DR = 4'h7,
      S_UP_DR = 4'h8, S_SEL_IR = 4'h9, S_CAP_IR = 4'ha, S_SH_IR = 4'hb,
      S_EX1_IR = 4'hc, S_PA_IR = 4'hd, S_EX2_IR = 4'he, S_UP_IR = 4'hf
   } jtp_state_t;

   // boot sequencer states
   typedef enum logic [1:0] {
      B_HOLD = 2'h0, B_LOCK = 2'h1, B_RUN = 2'h2
   } jtp_boot_t;

   // synchronised jtag pin bundle
   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
      logic trst_n;
   } jtp_pins_t;
endpackage : jtp_pkg

// File: core/jtp_tap.sv
// test access port with identification, user code and chip-level tap pass-through
// assumes clk_i much faster than the test clock; all jtag pins are asynchronous
`timescale 1ns/1ps
module jtp_tap
   import jtp_pkg::*;
(
   input  wire logic              clk_i,        // system clock, 125 MHz
   input  wire logic              nrst_i,       // synchronous reset, active low
   input  wire logic              rst_pin_n_i,  // global reset pin, active low
   input  wire logic              pll_lock_i,   // pll lock indication
   input  wire logic [31:0]       sec_reg_i,    // security register loaded from fuses
   input  wire logic              tck_i,        // test clock pin
   input  wire logic              tms_i,        // test mode select pin
   input  wire logic              tdi_i,        // test data in pin
   input  wire logic              trst_n_i,     // test reset pin, active low
   output logic                   tdo_o,        // test data out
   output logic                   tdo_oe_o,     // test data out enable
   input  wire logic              chip_tdo_i,   // serial out of chip-level tap
   output logic                   chip_tck_o,   // test clock edge strobe to chip tap
   output logic                   chip_tms_o,   // mode select to chip tap
   output logic                   chip_tdi_o,   // data into chip tap
   output logic                   chip_sel_o,   // chip tap selected
   output logic [DR_W-1:0]        bscan_o,      // boundary update value
   output logic                   boot_go_o     // boot sequence may start
);
   import jtp_pkg::*;

   // two-stage synchronisers; stage one is read only by stage two
   jtp_pins_t  s1_r, s2_r;
   logic       tck_d_r;                          // previous synced tck, for edge find
   logic       rst1_r, rst2_r;                   // global reset synchroniser
   logic       trst_any;                         // combined tap reset
   logic       rise, fall;                       // test clock edges

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         s1_r    <= '0;
         s2_r    <= '0;
         tck_d_r <= 1'b0;
      end else begin
         s1_r    <= '{tck: tck_i, tms: tms_i, tdi: tdi_i, trst_n: trst_n_i};
         s2_r    <= s1_r;
         tck_d_r <= s2_r.tck;
      end
   end

   // reset pin: asynchronous assert, synchronous release
   always_ff @(posedge clk_i or negedge rst_pin_n_i) begin
      if (!rst_pin_n_i) begin
         rst1_r <= 1'b0;
         rst2_r <= 1'b0;
      end else begin
         rst1_r <= 1'b1;
         rst2_r <= rst1_r;
      end
   end

   assign rise = s2_r.tck & ~tck_d_r;
   assign fall = ~s2_r.tck & tck_d_r;
   // test reset pin tied low holds the whole port in reset; so does the fuse lock
   assign trst_any = ~s2_r.trst_n | sec_reg_i[SEC_JTAG_OFF] | ~rst2_r;

   // tap controller state
   jtp_state_t st_r, st_nxt;
   logic [IR_W-1:0] ir_sh_r, ir_sh_nxt, ir_r, ir_nxt;
   logic [DR_W-1:0] dr_r, dr_nxt, bs_r, bs_nxt;
   logic            tdo_r, tdo_nxt, oe_r, oe_nxt;
   logic [DR_W-1:0] id_word, uc_word;

   // identification word: version, part, maker, bit 0 fixed one
   assign id_word = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
   // user word: tag from the security register, zero gap, revision low
   assign uc_word = {sec_reg_i[SEC_TAG_LSB +: UC_TAG_W],
                     {(UC_TAG_LSB-UC_REV_W){1'b0}}, SILICON_REV};

   // next state of the controller on each rising test clock edge
   always_comb begin
      st_nxt = st_r;
      if (rise) begin
         case (st_r)
            S_RESET:  st_nxt = s2_r.tms ? S_RESET  : S_IDLE;
            S_IDLE:   st_nxt = s2_r.tms ? S_SEL_DR : S_IDLE;
            S_SEL_DR: st_nxt = s2_r.tms ? S_SEL_IR : S_CAP_DR;
            S_CAP_DR: st_nxt = s2_r.tms ? S_EX1_DR : S_SH_DR;
            S_SH_DR:  st_nxt = s2_r.tms ? S_EX1_DR : S_SH_DR;
            S_EX1_DR: st_nxt = s2_r.tms ? S_UP_DR  : S_PA_DR;
            S_PA_DR:  st_nxt = s2_r.tms ? S_EX2_DR : S_PA_DR;
            S_EX2_DR: st_nxt = s2_r.tms ? S_UP_DR  : S_SH_DR;
            S_UP_DR:  st_nxt = s2_r.tms ? S_SEL_DR : S_IDLE;
            S_SEL_IR: st_nxt = s2_r.tms ? S_RESET  : S_CAP_IR;
            S_CAP_IR: st_nxt = s2_r.tms ? S_EX1_IR : S_SH_IR;
            S_SH_IR:  st_nxt = s2_r.tms ? S_EX1_IR : S_SH_IR;
            S_EX1_IR: st_nxt = s2_r.tms ? S_UP_IR  : S_PA_IR;
            S_PA_IR:  st_nxt = s2_r.tms ? S_EX2_IR : S_PA_IR;
            S_EX2_IR: st_nxt = s2_r.tms ? S_UP_IR  : S_SH_IR;
            S_UP_IR:  st_nxt = s2_r.tms ? S_SEL_DR : S_IDLE;
            default:  st_nxt = S_RESET;
         endcase
      end
   end

   // instruction and data registers; capture/shift on rising, tdo on falling
   always_comb begin
      ir_sh_nxt = ir_sh_r;
      ir_nxt    = ir_r;
      dr_nxt    = dr_r;
      bs_nxt    = bs_r;
      tdo_nxt   = tdo_r;
      oe_nxt    = oe_r;
      // test-logic-reset reloads the identification instruction on every clock
      if (st_r == S_RESET)
         ir_nxt = INS_DEVICE_IDENTIFICATION_WORD;
      if (rise) begin
         case (st_r)
            S_CAP_IR: ir_sh_nxt = IR_CAPTURE;
            S_SH_IR:  ir_sh_nxt = {s2_r.tdi, ir_sh_r[IR_W-1:1]};
            S_UP_IR:  ir_nxt = ir_sh_r;
            S_CAP_DR: begin
               case (ir_r)
                  INS_DEVICE_IDENTIFICATION_WORD:   dr_nxt = id_word;
                  INS_USERCODE: dr_nxt = uc_word;
                  INS_SAMPLE,
                  INS_EXTEST:   dr_nxt = bs_r;
                  default:      dr_nxt = '0;
               endcase
            end
            S_SH_DR: begin
               if (ir_r == INS_BYPASS)
                  dr_nxt = {31'h0, s2_r.tdi};              // one-bit bypass
               else
                  dr_nxt = {s2_r.tdi, dr_r[DR_W-1:1]};
            end
            S_UP_DR: begin
               if (ir_r == INS_EXTEST || ir_r == INS_SAMPLE)
                  bs_nxt = dr_r;
            end
            default: ;
         endcase
      end
      if (fall) begin
         // output changes on the falling test clock edge only
         oe_nxt = (st_r == S_SH_DR) || (st_r == S_SH_IR);
         if (st_r == S_SH_IR)
            tdo_nxt = ir_sh_r[0];
         else if (ir_r == INS_CHIPTAP)
            tdo_nxt = chip_tdo_i;
         else
            tdo_nxt = dr_r[0];
      end
   end

   // registers of the controller; tap reset state loads identification
   always_ff @(posedge clk_i) begin
      if (!nrst_i || trst_any) begin
         st_r    <= S_RESET;
         ir_sh_r <= '0;
         ir_r    <= INS_DEVICE_IDENTIFICATION_WORD;
         dr_r    <= '0;
         bs_r    <= '0;
         tdo_r   <= 1'b0;
         oe_r    <= 1'b0;
      end else begin
         st_r    <= st_nxt;
         ir_sh_r <= ir_sh_nxt;
         ir_r    <= ir_nxt;
         dr_r    <= dr_nxt;
         bs_r    <= bs_nxt;
         tdo_r   <= tdo_nxt;
         oe_r    <= oe_nxt;
      end
   end

   // chip-level tap sees the pins only while selected; tck forwarded as edge strobe
   assign chip_sel_o = (ir_r == INS_CHIPTAP) && !trst_any;
   assign chip_tck_o = chip_sel_o & rise;
   assign chip_tms_o = chip_sel_o & s2_r.tms;
   assign chip_tdi_o = chip_sel_o & s2_r.tdi;
   assign tdo_o      = tdo_r;
   assign tdo_oe_o   = oe_r;
   assign bscan_o    = bs_r;

   // boot sequencer: after reset release wait for pll lock, then run
   jtp_boot_t bt_r, bt_nxt;
   logic      lk1_r, lk2_r;                                 // lock synchroniser

   always_comb begin
      bt_nxt = bt_r;
      case (bt_r)
         B_HOLD:  bt_nxt = rst2_r ? B_LOCK : B_HOLD;
         B_LOCK:  bt_nxt = lk2_r ? B_RUN : B_LOCK;
         B_RUN:   bt_nxt = B_RUN;
         default: bt_nxt = B_HOLD;
      endcase
      if (!rst2_r)
         bt_nxt = B_HOLD;
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         bt_r  <= B_HOLD;
         lk1_r <= 1'b0;
         lk2_r <= 1'b0;
      end else begin
         bt_r  <= bt_nxt;
         lk1_r <= pll_lock_i;
         lk2_r <= lk1_r;
      end
   end

   assign boot_go_o = (bt_r == B_RUN);
endmodule : jtp_tap

// File: sim/jtp_tap_props.sv
// checker for the test access port: reset gating, strobes, boot order
// assumes it is bound into jtp_tap and sees only that module's ports
`timescale 1ns/1ps
module jtp_tap_props (
   input logic        clk_i,
   input logic        nrst_i,
   input logic        rst_pin_n_i,
   input logic        pll_lock_i,
   input logic [31:0] sec_reg_i,
   input logic        tck_i,
   input logic        trst_n_i,
   input logic        tdo_o,
   input logic        tdo_oe_o,
   input logic        chip_tck_o,
   input logic        chip_sel_o,
   input logic        boot_go_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   // reset sources held long enough to pass the two-flop sync
   sequence s_trst; !trst_n_i [*5]; endsequence
   sequence s_fuse; sec_reg_i[0] [*5]; endsequence
   // test clock parked low, no reset source active
   sequence s_park; (!tck_i && trst_n_i && rst_pin_n_i && !sec_reg_i[0]) [*8]; endsequence
   a_reset_quiet: assert property (disable iff (1'b0) !nrst_i |=> !tdo_oe_o && !boot_go_o)
      else $error("outputs kept through reset");
   a_trst_off: assert property (s_trst |-> !tdo_oe_o && !chip_sel_o)
      else $error("tap live under test reset");
   a_fuse_off: assert property (s_fuse |-> !tdo_oe_o && !chip_sel_o)
      else $error("tap live while disabled");
   a_pin_off: assert property (!rst_pin_n_i [*3] |-> !boot_go_o && !tdo_oe_o)
      else $error("global reset ignored");
   a_boot_lock: assert property ($rose(boot_go_o) |-> $past(pll_lock_i, 3))
      else $error("boot before lock");
   a_chip_gate: assert property (chip_tck_o |->
         chip_sel_o && $past(tck_i, 2) && !$past(tck_i, 3))
      else $error("chip strobe without selected test clock rise");
   a_chip_pulse: assert property (chip_tck_o |=> !chip_tck_o)
      else $error("chip strobe too long");
   a_tdo_holds: assert property (s_park |-> $stable(tdo_o))
      else $error("tdo moved without clock");
endmodule : jtp_tap_props
bind jtp_tap jtp_tap_props chk_u (.clk_i(clk_i), .nrst_i(nrst_i), .rst_pin_n_i(rst_pin_n_i),
   .pll_lock_i(pll_lock_i), .sec_reg_i(sec_reg_i), .tck_i(tck_i), .trst_n_i(trst_n_i),
   .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .chip_tck_o(chip_tck_o), .chip_sel_o(chip_sel_o),
   .boot_go_o(boot_go_o));

// File: sim/jtp_host.sv
// jtag host model: drives the test pins, parks the clock low between frames
// assumes a tap that takes tms and tdi on the rising test clock
`timescale 1ns/1ps
module jtp_host (
   output logic tck_o,
   output logic tms_o,
   output logic tdi_o,
   output logic trst_n_o,
   input  logic tdo_i
);
   // test reset low through power-up and beyond 100 ns
   initial begin
      tck_o = 1'b0;
      tms_o = 1'b0;
      tdi_o = 1'b0;
      trst_n_o = 1'b0;
      #205 trst_n_o = 1'b1;
   end
   // one 64 ns period; tdo read late since it settles clocks after the fall
   task automatic bit1(input logic m, input logic d, output logic q);
      tms_o = m;
      tdi_o = d;
      #32 tck_o = 1'b1;
      // read just before a system clock edge, never on one
      #30 q = tdo_i;
      #2 tck_o = 1'b0;
   endtask : bit1
   // idle to shift, n bits lsb first, then back to idle
   task automatic shift(input logic ir, input logic [31:0] din, input int n,
                        output logic [31:0] q);
      logic b;
      q = '0;
      bit1(1'b1, 1'b0, b);
      if (ir) bit1(1'b1, 1'b0, b);
      bit1(1'b0, 1'b0, b);
      bit1(1'b0, 1'b0, b);
      for (int i = 0; i < n; i++) begin
         bit1(i == n - 1, din[i], b);
         q[i] = b;
      end
      // exit bits carry the inverse of the last data bit, so stale tdi shows
      bit1(1'b1, ~din[n-1], b);
      bit1(1'b0, ~din[n-1], b);
   endtask : shift
   task automatic reset_tap();
      logic b;
      trst_n_o = 1'b0;
      #200 trst_n_o = 1'b1;
      #64 bit1(1'b0, 1'b0, b);
   endtask : reset_tap
endmodule : jtp_host

// File: sim/test_jtp_tap.sv
// self-checking bench: host model on the test pins, boot pins from here
// assumes jtp_host and the bound checker are compiled alongside
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin fails++; \
   $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module test_jtp_tap;
   import jtp_pkg::*;
   localparam logic [31:0] ID_EXP = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
   logic clk_i = 1'b0, nrst_i = 1'b0, rst_pin_n_i = 1'b0, pll_lock_i = 1'b1;
   logic tck, tms, tdi, trst_n, tdo_o, tdo_oe_o, chip_tdo_i = 1'b1, oe_seen = 1'b0;
   logic chip_tck_o, chip_tms_o, chip_tdi_o, chip_sel_o, boot_go_o;
   logic [31:0] sec_reg_i = '0, bscan_o, q;
   int fails = 0, samples_checked = 0, cyc = 0, pulses = 0, tms_hi = 0, tdi_hi = 0;
   initial forever #4 clk_i = ~clk_i;
   // cycle ceiling, chip strobe count, enable watch
   always @(posedge clk_i) begin
      cyc++;
      if (chip_tck_o === 1'b1) pulses++;
      if (chip_tck_o === 1'b1 && chip_tms_o === 1'b1) tms_hi++;
      if (chip_tck_o === 1'b1 && chip_tdi_o === 1'b1) tdi_hi++;
      if (tdo_oe_o === 1'b1) oe_seen = 1'b1;
      if (cyc == 20000) begin
         fails++;
         finish_test();
      end
   end
   // a released tdo shows the inverse of its last value to the host
   jtp_host host_u (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .trst_n_o(trst_n),
      .tdo_i(tdo_oe_o ? tdo_o : ~tdo_o));
   jtp_tap dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .rst_pin_n_i(rst_pin_n_i),
      .pll_lock_i(pll_lock_i), .sec_reg_i(sec_reg_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
      .trst_n_i(trst_n), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .chip_tdo_i(chip_tdo_i),
      .chip_tck_o(chip_tck_o), .chip_tms_o(chip_tms_o), .chip_tdi_o(chip_tdi_o),
      .chip_sel_o(chip_sel_o), .bscan_o(bscan_o), .boot_go_o(boot_go_o));
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : tick
   task automatic load_ir(input logic [3:0] ins);
      host_u.shift(1'b1, {28'h0, ins}, IR_W, q);
      `CHK(q[3:0], IR_CAPTURE)
   endtask : load_ir
   task automatic t_device_identification_word();
      host_u.reset_tap();
      host_u.shift(1'b0, '0, DR_W, q);
      `CHK(q, ID_EXP)
      load_ir(INS_USERCODE);
      host_u.reset_tap();
      host_u.shift(1'b0, '0, DR_W, q);
      `CHK(q, ID_EXP)
   endtask : t_device_identification_word
   // blank fuses first, then a tag with the unused gap bits set
   task automatic t_user();
      logic [31:0] s;
      for (int k = 0; k < 2; k++) begin
         s = k ? 32'ha5ff_fffe : 32'h0;
         tick(1);
         sec_reg_i = s;
         load_ir(INS_USERCODE);
         host_u.shift(1'b0, '0, DR_W, q);
         `CHK(q, {s[31:22], 14'h0, SILICON_REV})
      end
   endtask : t_user
   task automatic t_pass();
      // sample loads the update register, extest captures it back
      load_ir(INS_SAMPLE);
      host_u.shift(1'b0, 32'hc3a5_0f96, DR_W, q);
      `CHK(bscan_o, 32'hc3a5_0f96)
      load_ir(INS_EXTEST);
      host_u.shift(1'b0, '0, DR_W, q);
      `CHK(q, 32'hc3a5_0f96)
      `CHK(bscan_o, 32'h0)
      load_ir(INS_BYPASS);
      host_u.shift(1'b0, 32'h1234_5678, DR_W, q);
      `CHK(q, 32'h2468_acf0)
      load_ir(INS_CHIPTAP);
      `CHK(chip_sel_o, 1'b1)
      pulses = 0;
      tms_hi = 0;
      tdi_hi = 0;
      host_u.shift(1'b0, 32'h0000_000f, DR_W, q);
      tick(2);
      `CHK(q, 32'hffff_ffff)
      `CHK(pulses, 37)
      `CHK(tms_hi, 3)
      `CHK(tdi_hi, 6)
      load_ir(INS_DEVICE_IDENTIFICATION_WORD);
      `CHK(chip_sel_o, 1'b0)
   endtask : t_pass
   task automatic t_lock();
      tick(1);
      sec_reg_i = 32'h1;
      oe_seen = 1'b0;
      host_u.shift(1'b0, '0, DR_W, q);
      `CHK(oe_seen, 1'b0)
      sec_reg_i = '0;
      pll_lock_i = 1'b0;
      rst_pin_n_i = 1'b0;
      tick(3);
      `CHK(boot_go_o, 1'b0)
      rst_pin_n_i = 1'b1;
      tick(20);
      `CHK(boot_go_o, 1'b0)
      pll_lock_i = 1'b1;
      tick(8);
      `CHK(boot_go_o, 1'b1)
   endtask : t_lock
   task automatic finish_test();
      $display("checks %0d fails %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : finish_test
   initial begin
      tick(2);
      nrst_i = 1'b1;
      tick(25);
      rst_pin_n_i = 1'b1;
      tick(10);
      `CHK(boot_go_o, 1'b1)
      t_device_identification_word();
      t_user();
      t_pass();
      t_lock();
      finish_test();
   end
endmodule : test_jtp_tap
